// >>> hw/smbus_cfg_pkg.sv
// constants for the serial bus configuration and timeout logic
package smbus_cfg_pkg;
    localparam logic [7:0] CFG_ADDR = 8'hC1;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int BIT_ENABLE = 7;
    localparam int BIT_SLAVE_MASK = 6;
    localparam int BIT_BUSY = 5;
    localparam int BIT_EXT_SDA = 4;
    localparam int BIT_SCL_TIMEOUT = 3;
    localparam int BIT_FREE_TIMEOUT = 2;
    localparam int BIT_CLK_SEL_LO = 0;
    localparam logic [1:0] SRC_TIMER0 = 2'h0;
    localparam logic [1:0] SRC_TIMER1 = 2'h1;
    localparam logic [1:0] SRC_TIMER2_HIGH = 2'h2;
    localparam logic [1:0] SRC_TIMER2_LOW = 2'h3;
    localparam logic [3:0] FREE_TICKS = 4'hA;
endpackage : smbus_cfg_pkg

// >>> hw/smbus_link_if.sv
// clock-crossing signals between the configuration logic and the line monitor
`timescale 1ns/100ps
interface smbus_link_if;
    logic monitorEnable;
    logic startToggle;
    logic stopToggle;
    modport mon (input monitorEnable, output startToggle, output stopToggle);
    modport ctl (output monitorEnable, input startToggle, input stopToggle);
endinterface : smbus_link_if

// >>> hw/smbus_line_monitor.sv
// start and stop detection on the bus lines, in the link clock domain
`timescale 1ns/100ps
module smbus_line_monitor
    import smbus_cfg_pkg::*;
(
    input wire logic clkLink,
    input wire logic reset,
    input wire logic sclPin,
    input wire logic sdaPin,
    smbus_link_if.mon link
);
    logic resetMeta, linkReset;
    logic enMeta, enSync;
    logic sclMeta, sclSync, sclPrev;
    logic sdaMeta, sdaSync, sdaPrev;
    logic startToggle, stopToggle;
    wire startSeen = enSync && sclSync && sclPrev && sdaPrev && !sdaSync;
    wire stopSeen = enSync && sclSync && sclPrev && !sdaPrev && sdaSync;

    always_ff @(posedge clkLink) begin
        resetMeta <= reset;
        linkReset <= resetMeta;
    end

    always_ff @(posedge clkLink) begin
        if (linkReset) begin
            {enMeta, enSync} <= 2'h0;
            {sclMeta, sclSync, sclPrev} <= 3'h7;
            {sdaMeta, sdaSync, sdaPrev} <= 3'h7;
        end else begin
            enMeta <= link.monitorEnable;
            enSync <= enMeta;
            sclMeta <= sclPin;
            sclSync <= sclMeta;
            sclPrev <= sclSync;
            sdaMeta <= sdaPin;
            sdaSync <= sdaMeta;
            sdaPrev <= sdaSync;
        end
    end

    // toggles survive the crossing even if the system clock is slower
    always_ff @(posedge clkLink) begin
        if (linkReset) begin
            startToggle <= 1'b0;
            stopToggle <= 1'b0;
        end else begin
            if (startSeen) startToggle <= ~startToggle;
            if (stopSeen) stopToggle <= ~stopToggle;
        end
    end

    assign link.startToggle = startToggle;
    assign link.stopToggle = stopToggle;

    AST_START_TOGGLES: assert property (@(posedge clkLink) disable iff (linkReset)
        startSeen |=> startToggle != $past(startToggle))
        else $error("start not flagged");
endmodule : smbus_line_monitor

// >>> hw/smbus_config_timeout_logic.sv
// configuration register, busy flag and timeout control of the serial bus
`timescale 1ns/100ps
module smbus_config_timeout_logic
    import smbus_cfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clkLink,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWriteData,
    input wire logic sfrRead,
    output logic [7:0] sfrReadData,
    input wire logic sclPin,
    input wire logic sdaPin,
    input wire logic timer0Overflow,
    input wire logic timer1Overflow,
    input wire logic timer2HighOverflow,
    input wire logic timer2LowOverflow,
    input wire logic timer3Split,
    input wire logic slaveEvent,
    input wire logic masterEvent,
    output logic timer3ReloadHigh,
    output logic timer3ReloadLow,
    output logic interfaceEnable,
    output logic extendedSdaTiming,
    output logic bitRateTick,
    output logic busy,
    output logic busFree,
    output logic interruptRequest
);
    function automatic logic isCfgAddr(input logic [7:0] addr);
        return addr == CFG_ADDR;
    endfunction : isCfgAddr

    smbus_link_if link ();

    logic [7:0] cfg;
    logic sclMeta, sclHigh, sdaMeta, sdaHigh;
    logic [2:0] startSync, stopSync;
    logic [3:0] freeCount;
    logic [3:0] next_freeCount;
    logic next_busy;

    wire cfgWrite = sfrWrite && isCfgAddr(sfrAddr);
    wire cfgRead = sfrRead && isCfgAddr(sfrAddr);
    wire enable = cfg[BIT_ENABLE];
    wire slaveMask = cfg[BIT_SLAVE_MASK];
    wire sclTimeoutEn = cfg[BIT_SCL_TIMEOUT];
    wire freeTimeoutEn = cfg[BIT_FREE_TIMEOUT];
    wire [1:0] clkSel = cfg[BIT_CLK_SEL_LO +: 2];
    wire [7:0] cfgView = {cfg[7:6], busy, cfg[4:0]};
    wire startEvt = startSync[2] ^ startSync[1];
    wire stopEvt = stopSync[2] ^ stopSync[1];
    wire linesHigh = sclHigh && sdaHigh;
    wire freeArmed = enable && freeTimeoutEn;
    wire freeEvt = freeArmed && linesHigh && bitRateTick && freeCount == FREE_TICKS;
    wire reloadHighNow = enable && sclTimeoutEn && sclHigh;
    wire irqNow = enable && (masterEvent || (slaveEvent && !slaveMask));

    assign link.monitorEnable = enable;

    smbus_line_monitor monitor (
        .clkLink(clkLink),
        .reset(reset),
        .sclPin(sclPin),
        .sdaPin(sdaPin),
        .link(link)
    );

    always_comb begin
        case (clkSel)
            SRC_TIMER0: bitRateTick = timer0Overflow;
            SRC_TIMER1: bitRateTick = timer1Overflow;
            SRC_TIMER2_HIGH: bitRateTick = timer2HighOverflow;
            SRC_TIMER2_LOW: bitRateTick = timer2LowOverflow;
            default: bitRateTick = 1'b0;
        endcase
    end

    // busy and software write-back of bit 5 are independent: bit 5 is read-only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg <= CFG_RESET;
        end else if (cfgWrite) begin
            cfg <= {sfrWriteData[7:6], 1'b0, sfrWriteData[4:0]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sfrReadData <= 8'h00;
        end else begin
            sfrReadData <= cfgRead ? cfgView : 8'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            {sclMeta, sclHigh, sdaMeta, sdaHigh} <= 4'hF;
            startSync <= 3'h0;
            stopSync <= 3'h0;
        end else begin
            sclMeta <= sclPin;
            sclHigh <= sclMeta;
            sdaMeta <= sdaPin;
            sdaHigh <= sdaMeta;
            startSync <= {startSync[1:0], link.startToggle};
            stopSync <= {stopSync[1:0], link.stopToggle};
        end
    end

    always_comb begin
        next_freeCount = freeCount;
        if (!freeArmed || !linesHigh) begin
            next_freeCount = 4'h0;
        end else if (bitRateTick && freeCount <= FREE_TICKS) begin
            next_freeCount = freeCount + 4'h1;
        end
    end

    // a start in the same cycle as a stop wins: a new transfer began
    always_comb begin
        next_busy = busy;
        if (!enable) begin
            next_busy = 1'b0;
        end else if (startEvt) begin
            next_busy = 1'b1;
        end else if (stopEvt || freeEvt) begin
            next_busy = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            freeCount <= 4'h0;
            busy <= 1'b0;
            busFree <= 1'b1;
        end else begin
            freeCount <= next_freeCount;
            busy <= next_busy;
            busFree <= next_freeCount > FREE_TICKS;
        end
    end

    // timer reload lines are idle while disabled so the timer runs as software set it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            timer3ReloadHigh <= 1'b0;
            timer3ReloadLow <= 1'b0;
        end else begin
            timer3ReloadHigh <= reloadHighNow;
            timer3ReloadLow <= reloadHighNow && !timer3Split;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            interfaceEnable <= 1'b0;
            extendedSdaTiming <= 1'b0;
            interruptRequest <= 1'b0;
        end else begin
            interfaceEnable <= enable;
            extendedSdaTiming <= cfg[BIT_EXT_SDA];
            interruptRequest <= irqNow;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence seqStart;
        enable && startEvt;
    endsequence

    sequence seqQuietEnd;
        freeArmed && linesHigh && bitRateTick && freeCount == FREE_TICKS && !startEvt;
    endsequence

    AST_START_SETS_BUSY: assert property (seqStart |=> busy)
        else $error("start did not set busy");
    AST_STOP_CLEARS_BUSY: assert property (enable && stopEvt && !startEvt |=> !busy)
        else $error("stop did not clear busy");
    AST_FREE_CLEARS_BUSY: assert property (seqQuietEnd |=> !busy && busFree)
        else $error("free timeout did not clear busy");
    AST_BUSY_READBACK: assert property (cfgRead |=> sfrReadData[BIT_BUSY] == $past(busy))
        else $error("busy not visible on read");
    AST_DISABLED_IDLE: assert property (!enable |=> !busy && !timer3ReloadHigh)
        else $error("disabled block still active");
    AST_RELOAD_SCL_HIGH: assert property (reloadHighNow |=> timer3ReloadHigh)
        else $error("timer not held in reload");
    AST_COUNT_SCL_LOW: assert property (!sclHigh |=> !timer3ReloadHigh && !timer3ReloadLow)
        else $error("timer held while scl low");
    AST_SPLIT_LOW_FREE: assert property (timer3Split |=> !timer3ReloadLow)
        else $error("low byte reloaded in split mode");
    AST_SLAVE_MASKED: assert property (slaveMask && !masterEvent |=> !interruptRequest)
        else $error("slave interrupt not masked");
    AST_MASTER_PASSES: assert property (enable && masterEvent |=> interruptRequest)
        else $error("master interrupt lost");
    AST_FREE_RESTART: assert property (!linesHigh |=> freeCount == 4'h0)
        else $error("free counter not restarted");
    AST_TICK_SOURCE: assert property (clkSel == SRC_TIMER2_LOW |-> bitRateTick == timer2LowOverflow)
        else $error("wrong tick source");
    AST_EXT_TIMING: assert property (cfgWrite |=> ##1 extendedSdaTiming == $past(sfrWriteData[4], 2))
        else $error("extended timing not applied");
endmodule : smbus_config_timeout_logic

// >>> dv/smbus_bus_partner.sv
// other party on the two-wire bus: makes start, stop and idle line patterns
`timescale 1ns/100ps
module smbus_bus_partner (
    output logic sclPin,
    output logic sdaPin
);
    // released open-drain lines sit at the pull-up level
    initial begin
        sclPin = 1'b1;
        sdaPin = 1'b1;
    end
    task automatic lines(input logic scl, input logic sda);
        sclPin = scl;
        sdaPin = sda;
        #60; // well over two link periods so the monitor sees each level
    endtask : lines
    task automatic sendStart();
        lines(1'b1, 1'b0);
        lines(1'b0, 1'b0);
    endtask : sendStart
    task automatic sendStop();
        lines(1'b0, 1'b0);
        lines(1'b1, 1'b0);
        lines(1'b1, 1'b1);
    endtask : sendStop
    // sda rises while scl is low, so no stop is seen
    task automatic sendRelease();
        lines(1'b0, 1'b1);
        lines(1'b1, 1'b1);
    endtask : sendRelease
endmodule : smbus_bus_partner

// >>> dv/tb.sv
// self-checking bench for the configuration and timeout logic
`timescale 1ns/100ps
module tb
    import smbus_cfg_pkg::*;
;
    logic clk_sys, reset, clkLink, sfrWrite, sfrRead, sclPin, sdaPin, timer3Split;
    logic slaveEvent, masterEvent, rlHigh, rlLow, enable, extSda, tick, busy, busFree, irq;
    logic [7:0] sfrAddr, sfrWriteData, sfrReadData, v;
    logic [3:0] ovf;
    logic [7:0] irqCfg [3] = '{8'h00, 8'h80, 8'hC0};
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int modelCfg = 0;
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        clkLink = 1'b0;
        #1.3;
        forever #6 clkLink = ~clkLink;
    end
    smbus_bus_partner partner_u (.sclPin(sclPin), .sdaPin(sdaPin));
    smbus_config_timeout_logic dut_u (.clk_sys(clk_sys), .reset(reset), .clkLink(clkLink),
        .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrWriteData(sfrWriteData),
        .sfrRead(sfrRead), .sfrReadData(sfrReadData), .sclPin(sclPin), .sdaPin(sdaPin),
        .timer0Overflow(ovf[0]), .timer1Overflow(ovf[1]), .timer2HighOverflow(ovf[2]),
        .timer2LowOverflow(ovf[3]), .timer3Split(timer3Split), .slaveEvent(slaveEvent),
        .masterEvent(masterEvent), .timer3ReloadHigh(rlHigh), .timer3ReloadLow(rlLow),
        .interfaceEnable(enable), .extendedSdaTiming(extSda), .bitRateTick(tick),
        .busy(busy), .busFree(busFree), .interruptRequest(irq));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic regWrite(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys);
        sfrAddr = addr;
        sfrWriteData = data;
        sfrWrite = 1'b1;
        if (addr == CFG_ADDR) modelCfg = int'(data & 8'hDF);
        @(negedge clk_sys);
        sfrWrite = 1'b0;
        @(negedge clk_sys);
    endtask : regWrite
    task automatic regRead(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge clk_sys);
        sfrAddr = addr;
        sfrRead = 1'b1;
        @(negedge clk_sys);
        sfrRead = 1'b0;
        check("read", sfrReadData, exp);
    endtask : regRead
    // busy crosses from the link domain, so allow a bounded settle
    task automatic waitBusy(input logic exp);
        for (int i = 0; i < 60 && busy !== exp; i++) @(negedge clk_sys);
        check("busy", {7'h00, busy}, {7'h00, exp});
    endtask : waitBusy
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge clk_sys);
            ovf[0] = 1'b1;
            @(negedge clk_sys);
            ovf[0] = 1'b0;
        end
    endtask : ticks
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        {reset, sfrWrite, sfrRead, sfrAddr, sfrWriteData} = {3'h4, 16'h0000};
        {ovf, timer3Split, slaveEvent, masterEvent} = 7'h00;
        void'($urandom(81));
        // two link edges inside reset plus two after release still reset the link side
        repeat (6) @(negedge clk_sys);
        reset = 1'b0;
        regRead(CFG_ADDR, CFG_RESET);
        regWrite(8'hC2, 8'hFF);
        regRead(8'hC2, 8'h00);
        regRead(CFG_ADDR, 8'h00);
        repeat (4) begin
            v = 8'($urandom) & 8'h7F; // enable off keeps busy low
            regWrite(CFG_ADDR, v | 8'h20);
            regRead(CFG_ADDR, 8'(modelCfg));
            check("model", 8'(modelCfg), v & 8'hDF);
            check("ext", {7'h00, extSda}, {7'h00, v[4]});
        end
        for (int s = 0; s < 4; s++) begin
            regWrite(CFG_ADDR, 8'(s));
            for (int k = 0; k < 4; k++) begin
                @(negedge clk_sys);
                ovf = 4'(1 << k);
                #1 check("tick", {7'h00, tick}, {7'h00, 1'(s == k)});
            end
            ovf = 4'h0;
        end
        $display("test registers done");
        foreach (irqCfg[i]) begin
            regWrite(CFG_ADDR, irqCfg[i]);
            for (int m = 0; m < 2; m++) begin
                @(negedge clk_sys);
                masterEvent = 1'(m);
                slaveEvent = 1'(1 - m);
                @(negedge clk_sys);
                {masterEvent, slaveEvent} = 2'h0;
                check("irq", {7'h00, irq}, {7'h00, irqCfg[i][7] & (m == 1 | !irqCfg[i][6])});
            end
        end
        $display("test interrupts done");
        regWrite(CFG_ADDR, 8'h80);
        repeat (4) @(negedge clk_sys);
        check("reload off", {6'h00, rlHigh, rlLow}, 8'h00);
        regWrite(CFG_ADDR, 8'h88);
        repeat (4) @(negedge clk_sys);
        check("reload", {6'h00, rlHigh, rlLow}, 8'h03);
        timer3Split = 1'b1;
        repeat (4) @(negedge clk_sys);
        check("reload split", {6'h00, rlHigh, rlLow}, 8'h02);
        partner_u.sendStart();
        waitBusy(1'b1);
        check("reload low scl", {6'h00, rlHigh, rlLow}, 8'h00);
        regRead(CFG_ADDR, 8'hA8);
        partner_u.sendStop();
        waitBusy(1'b0);
        $display("test scl timeout done");
        regWrite(CFG_ADDR, 8'h84);
        partner_u.sendStart();
        waitBusy(1'b1);
        partner_u.sendRelease();
        ticks(6);
        partner_u.sendRelease(); // short scl low restarts the count
        ticks(10);
        check("free early", {6'h00, busy, busFree}, 8'h02);
        ticks(1);
        @(negedge clk_sys);
        check("free", {6'h00, busy, busFree}, 8'h01);
        $display("test free timeout done");
        partner_u.sendStart();
        waitBusy(1'b1);
        // disabling mid-transfer must drop busy and keep it low through later starts and stops
        regWrite(CFG_ADDR, 8'h0C);
        partner_u.sendStop();
        partner_u.sendStart();
        partner_u.sendStop();
        repeat (4) @(negedge clk_sys);
        check("disabled", {5'h00, busy, rlHigh, rlLow}, 8'h00);
        $display("test disabled done");
        conclude();
    end
endmodule : tb
